//--- irq_fiq_consts.svh
/*
  Address map, field positions and reset values of the interrupt controller.
  Assumes a 32-bit AHB-Lite address space with word-aligned registers.
*/
`ifndef IRQ_FIQ_CONSTS_SVH
`define IRQ_FIQ_CONSTS_SVH

`define IRQ_MASKED_STATUS_ADDR 32'hffff0000
`define IRQ_RAW_SIGNAL_ADDR 32'hffff0004
`define IRQ_ENABLE_SET_ADDR 32'hffff0008
`define IRQ_ENABLE_CLEAR_ADDR 32'hffff000c
`define SOFTWARE_INTERRUPT_CONTROL_ADDR 32'hffff0010
`define VECTOR_BASE_ADDR 32'hffff0014
`define VECTOR_READBACK_ADDR 32'hffff001c
`define PRIORITY_BASE_ADDR 32'hffff0020
`define NESTING_CONTROL_ADDR 32'hffff0030
`define SERVICE_DONE_ADDR 32'hffff0034
`define FAST_MASKED_STATUS_ADDR 32'hffff0100
`define FAST_RAW_SIGNAL_ADDR 32'hffff0104
`define FAST_ENABLE_SET_ADDR 32'hffff0108
`define FAST_ENABLE_CLEAR_ADDR 32'hffff010c

`define SRC_COUNT 28
`define SWI_IRQ_BIT 1
`define SWI_FAST_BIT 2
`define NEST_IRQ_BIT 0
`define NEST_FAST_BIT 1
`define PRIO_FIELD_MASK 32'h77777777

`define ENABLE_RESET 32'h00000000
`define VECTOR_BASE_RESET 16'h0000
`define SWI_RESET 2'h0
`define NEST_RESET 2'h0

`endif

//--- irq_fiq_pkg.sv
/*
  Types shared by the interrupt controller: bus carriers, bus phase and the
  controller state record. Assumes the constants header is compiled first.
*/
package irq_fiq_pkg;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } ahb_in_type;

  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } ahb_out_type;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_WRITE = 3'b010,
    PH_READ = 3'b100
  } bus_phase_type;

  typedef struct packed {
    logic [31:0] req_meta;
    logic [31:0] req_sync;
    logic [31:0] irq_en;
    logic [31:0] fiq_en;
    logic [1:0] swi;
    logic [1:0] nest;
    logic [15:0] vbase;
    logic [3:0][31:0] prio;
    logic [7:0] in_service;
    bus_phase_type phase;
    logic [31:0] addr;
    logic [31:0] rdata;
    logic irq_out;
    logic fiq_out;
  } ctl_state_type;

endpackage

//--- irq_fiq_interrupt_controller.sv
/*
  Interrupt controller: peripheral request lines in, normal and fast request
  lines to the core out, registers on an AHB-Lite slave port.
  Assumes one clock, a single slave on the bus (hready is hreadyout), and
  peripheral request lines that may change at any time.
*/
// The AHB-Lite register port was left to the implementer.
`include "irq_fiq_consts.svh"

module irq_fiq_interrupt_controller #(
  parameter int SRC_COUNT = `SRC_COUNT
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Register bus.
  input wire irq_fiq_pkg::ahb_in_type ahb_i,
  output irq_fiq_pkg::ahb_out_type ahb_o,
  // Peripheral request lines, source 2 upward.
  input wire logic [SRC_COUNT-1:2] periph_irq_req,
  // Request lines to the core.
  output logic irq_req,
  output logic fiq_req
);
  import irq_fiq_pkg::*;

  if (SRC_COUNT < 3 || SRC_COUNT > 32) begin : g_bad_count
    $error("SRC_COUNT must lie between 3 and 32");
  end

  ctl_state_type s_ff;
  ctl_state_type nxt_s;
  logic [31:0] req_in;
  logic [31:0] irq_raw;
  logic [31:0] irq_masked;
  logic [31:0] fast_raw;
  logic [31:0] fast_masked;
  logic [31:1] fast_hi;
  logic fast_or;
  logic [3:0] best_lvl;
  logic [4:0] best_idx;
  logic [3:0] top_isr;
  logic take;
  logic irq_vec_mode;

  // Returns the top priority level and the lowest source number holding it.
  function automatic logic [8:0] pick_source(input logic [31:0] m,
                                             input logic [3:0][31:0] p);
    logic [3:0] lvl;
    logic [3:0] bl;
    logic [4:0] bi;
    bl = 4'h0;
    bi = 5'h00;
    lvl = 4'h0;
    for (int i = 31; i >= 0; i--) begin
      if (m[i]) begin
        if (i == 0) begin
          lvl = 4'h1;
        end else begin
          lvl = {1'b0, p[i / 8][(i % 8) * 4 +: 3]} + 4'h1;
        end
        if (lvl >= bl) begin
          bl = lvl;
          bi = 5'(i);
        end
      end
    end
    return {bl, bi};
  endfunction

  // Returns the highest level now in service, zero when none.
  function automatic logic [3:0] top_level(input logic [7:0] isr);
    logic [3:0] t;
    t = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (isr[i]) begin
        t = 4'(i + 1);
      end
    end
    return t;
  endfunction

  // Register read multiplexer; unmapped words read as zero.
  function automatic logic [31:0] read_word(input ctl_state_type s,
                                            input logic [31:0] ir,
                                            input logic [31:0] im,
                                            input logic [31:0] fr,
                                            input logic [31:0] fm,
                                            input logic [4:0] vi);
    logic [31:0] d;
    d = 32'h00000000;
    if (s.addr[31:4] == 28'(`PRIORITY_BASE_ADDR >> 4)) begin
      d = s.prio[s.addr[3:2]];
    end else begin
      unique case (s.addr)
        `IRQ_MASKED_STATUS_ADDR: d = im;
        `IRQ_RAW_SIGNAL_ADDR: d = ir;
        `IRQ_ENABLE_SET_ADDR: d = s.irq_en;
        `FAST_MASKED_STATUS_ADDR: d = fm;
        `FAST_RAW_SIGNAL_ADDR: d = fr;
        `FAST_ENABLE_SET_ADDR: d = s.fiq_en;
        `SOFTWARE_INTERRUPT_CONTROL_ADDR: d = {29'h0, s.swi, 1'b0};
        `VECTOR_BASE_ADDR: d = {16'h0000, s.vbase};
        `VECTOR_READBACK_ADDR: d = {9'h000, s.vbase, vi, 2'b00};
        `NESTING_CONTROL_ADDR: d = {30'h0, s.nest};
        default: d = 32'h00000000;
      endcase
    end
    return d;
  endfunction

  // Peripheral lines placed at their source bits.
  always_comb begin
    req_in = 32'h00000000;
    req_in[SRC_COUNT-1:2] = periph_irq_req;
  end

  // Raw and masked words; the software bits skip the mask.
  assign fast_hi = {s_ff.req_sync[31:2] & s_ff.fiq_en[31:2],
                    s_ff.swi[1]};
  assign fast_or = |fast_hi;
  assign fast_masked = {fast_hi, fast_or};
  assign fast_raw = {s_ff.req_sync[31:2], s_ff.swi[1], fast_or};
  assign irq_raw = {s_ff.req_sync[31:2], s_ff.swi[0], fast_or};
  assign irq_masked = {s_ff.req_sync[31:2] & s_ff.irq_en[31:2], s_ff.swi[0],
                       fast_or & s_ff.irq_en[0]};

  assign irq_vec_mode = s_ff.nest[`NEST_IRQ_BIT];
  assign {best_lvl, best_idx} = pick_source(irq_masked, s_ff.prio);
  assign top_isr = top_level(s_ff.in_service);
  assign take = ahb_i.hsel & ahb_i.htrans[1] & ahb_i.hready;

  always_comb begin
    nxt_s = s_ff;
    // Two-stage capture of the request lines.
    nxt_s.req_meta = req_in;
    nxt_s.req_sync = s_ff.req_meta;
    // Without vectored mode the line is a plain OR; with it, only a level
    // above everything in service is signalled.
    if (irq_vec_mode) begin
      nxt_s.irq_out = best_lvl > top_isr;
    end else begin
      nxt_s.irq_out = |irq_masked;
    end
    nxt_s.fiq_out = fast_or;
    unique case (s_ff.phase)
      PH_WRITE: begin
        if (s_ff.addr[31:4] == 28'(`PRIORITY_BASE_ADDR >> 4)) begin
          nxt_s.prio[s_ff.addr[3:2]] =
            ahb_i.hwdata & `PRIO_FIELD_MASK;
        end
        unique case (s_ff.addr)
          `IRQ_ENABLE_SET_ADDR: begin
            nxt_s.irq_en = s_ff.irq_en | ahb_i.hwdata;
            nxt_s.fiq_en = s_ff.fiq_en & ~ahb_i.hwdata;
          end
          `IRQ_ENABLE_CLEAR_ADDR: begin
            nxt_s.irq_en = s_ff.irq_en & ~ahb_i.hwdata;
          end
          `FAST_ENABLE_SET_ADDR: begin
            nxt_s.fiq_en = s_ff.fiq_en | ahb_i.hwdata;
            nxt_s.irq_en = s_ff.irq_en & ~ahb_i.hwdata;
          end
          `FAST_ENABLE_CLEAR_ADDR: begin
            nxt_s.fiq_en = s_ff.fiq_en & ~ahb_i.hwdata;
          end
          `SOFTWARE_INTERRUPT_CONTROL_ADDR: begin
            nxt_s.swi = {ahb_i.hwdata[`SWI_FAST_BIT],
                         ahb_i.hwdata[`SWI_IRQ_BIT]};
          end
          `VECTOR_BASE_ADDR: begin
            nxt_s.vbase = ahb_i.hwdata[15:0];
          end
          `NESTING_CONTROL_ADDR: begin
            nxt_s.nest = ahb_i.hwdata[1:0];
            if (!ahb_i.hwdata[`NEST_IRQ_BIT]) begin
              nxt_s.in_service = 8'h00;
            end
          end
          `SERVICE_DONE_ADDR: begin
            if (top_isr != 4'h0) begin
              nxt_s.in_service[3'(top_isr - 4'h1)] = 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
      PH_READ: begin
        nxt_s.rdata = read_word(s_ff, irq_raw, irq_masked, fast_raw,
                                fast_masked, best_idx);
        // Reading the vector in vectored mode marks its level in service.
        if (s_ff.addr == `VECTOR_READBACK_ADDR && irq_vec_mode &&
            best_lvl != 4'h0) begin
          nxt_s.in_service[3'(best_lvl - 4'h1)] = 1'b1;
        end
      end
      PH_IDLE: begin
      end
      default: begin
        nxt_s.phase = PH_IDLE;
      end
    endcase
    // Reads hold one wait state so the answer comes from a flip-flop.
    if (s_ff.phase == PH_READ) begin
      nxt_s.phase = PH_IDLE;
    end else if (take) begin
      nxt_s.phase = ahb_i.hwrite ? PH_WRITE : PH_READ;
      nxt_s.addr = ahb_i.haddr;
    end else begin
      nxt_s.phase = PH_IDLE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_ff <= '0;
      s_ff.irq_en <= `ENABLE_RESET;
      s_ff.fiq_en <= `ENABLE_RESET;
      s_ff.swi <= `SWI_RESET;
      s_ff.nest <= `NEST_RESET;
      s_ff.vbase <= `VECTOR_BASE_RESET;
      s_ff.phase <= PH_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign ahb_o.hreadyout = s_ff.phase != PH_READ;
  assign ahb_o.hresp = 1'b0;
  assign ahb_o.hrdata = s_ff.rdata;
  assign irq_req = s_ff.irq_out;
  assign fiq_req = s_ff.fiq_out;

  // Checks.
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic wr_irq_set;
  logic wr_irq_clr;
  logic wr_fast_set;
  logic wr_fast_clr;
  logic wr_swi;
  assign wr_irq_set = s_ff.phase == PH_WRITE &&
                      s_ff.addr == `IRQ_ENABLE_SET_ADDR;
  assign wr_irq_clr = s_ff.phase == PH_WRITE &&
                      s_ff.addr == `IRQ_ENABLE_CLEAR_ADDR;
  assign wr_fast_set = s_ff.phase == PH_WRITE &&
                       s_ff.addr == `FAST_ENABLE_SET_ADDR;
  assign wr_fast_clr = s_ff.phase == PH_WRITE &&
                       s_ff.addr == `FAST_ENABLE_CLEAR_ADDR;
  assign wr_swi = s_ff.phase == PH_WRITE &&
                  s_ff.addr == `SOFTWARE_INTERRUPT_CONTROL_ADDR;

  chk_irq_line_or: assert property (
    !irq_vec_mode |=> irq_req == $past(|irq_masked))
    else $error("normal request is not the OR of masked status");

  chk_raw_follows: assert property (
    $past(hresetn, 2) |->
      irq_raw[SRC_COUNT-1:2] == $past(periph_irq_req, 2) &&
      fast_raw[SRC_COUNT-1:2] == $past(periph_irq_req, 2))
    else $error("raw bits do not follow peripheral lines");

  chk_enable_set: assert property (
    wr_irq_set |=>
      (s_ff.irq_en & $past(ahb_i.hwdata)) == $past(ahb_i.hwdata) &&
      (s_ff.irq_en & ~$past(ahb_i.hwdata)) ==
      ($past(s_ff.irq_en) & ~$past(ahb_i.hwdata)))
    else $error("normal enable set write misbehaves");

  chk_mask_clear: assert property (
    wr_irq_clr |=> s_ff.irq_en == ($past(s_ff.irq_en) & ~$past(ahb_i.hwdata)))
    else $error("normal mask clear write misbehaves");

  chk_fast_line: assert property (
    ##1 fiq_req == $past(|fast_masked[31:1]) && irq_raw[0] == fast_or &&
      fast_raw[0] == fast_or)
    else $error("fast request or its summary bit is wrong");

  chk_fast_exclusive: assert property (
    wr_fast_set |=> (s_ff.irq_en & $past(ahb_i.hwdata)) == 32'h00000000 &&
      (s_ff.fiq_en & $past(ahb_i.hwdata)) == $past(ahb_i.hwdata))
    else $error("fast enable set did not clear normal enable");

  chk_irq_exclusive: assert property (
    wr_irq_set |=> (s_ff.fiq_en & $past(ahb_i.hwdata)) == 32'h00000000)
    else $error("normal enable set did not clear fast enable");

  chk_fast_clear: assert property (
    wr_fast_clr |=> s_ff.fiq_en == ($past(s_ff.fiq_en) & ~$past(ahb_i.hwdata)))
    else $error("fast mask clear write misbehaves");

  chk_swi_bypass: assert property (
    wr_swi |=> irq_raw[1] == $past(ahb_i.hwdata[1]) &&
      irq_masked[1] == $past(ahb_i.hwdata[1]) &&
      fast_masked[1] == $past(ahb_i.hwdata[2]))
    else $error("software interrupt bits not reflected");

  chk_vector_word: assert property (
    s_ff.phase == PH_READ && s_ff.addr == `VECTOR_READBACK_ADDR |=>
      ahb_o.hrdata[31:23] == 9'h000 && ahb_o.hrdata[1:0] == 2'b00 &&
      ahb_o.hrdata[22:7] == $past(s_ff.vbase) &&
      ahb_o.hrdata[6:2] == $past(best_idx) && ahb_o.hreadyout)
    else $error("vector readback word is wrong");

  chk_nest_gate: assert property (
    irq_vec_mode && best_lvl <= top_isr |=> !irq_req)
    else $error("normal request raised without higher level");

  chk_read_wait: assert property (
    s_ff.phase == PH_READ |-> !ahb_o.hreadyout ##1 ahb_o.hreadyout)
    else $error("read wait state is not exactly one cycle");

  chk_masked_read: assert property (
    s_ff.phase == PH_READ && s_ff.addr == `IRQ_MASKED_STATUS_ADDR |=>
      ahb_o.hrdata[31:2] == $past(irq_raw[31:2] & s_ff.irq_en[31:2]))
    else $error("normal masked status is not raw AND enable");

  chk_fast_masked: assert property (
    s_ff.phase == PH_READ && s_ff.addr == `FAST_MASKED_STATUS_ADDR |=>
      ahb_o.hrdata[31:2] == $past(fast_raw[31:2] & s_ff.fiq_en[31:2]))
    else $error("fast masked status is not raw AND enable");

  chk_fast_set: assert property (
    wr_fast_set |=> (s_ff.fiq_en & ~$past(ahb_i.hwdata)) ==
      ($past(s_ff.fiq_en) & ~$past(ahb_i.hwdata)))
    else $error("fast enable set write changed other bits");

  chk_base_upper: assert property (
    s_ff.phase == PH_READ && s_ff.addr == `VECTOR_BASE_ADDR |=>
      ahb_o.hrdata == {16'h0000, $past(s_ff.vbase)})
    else $error("vector base read is wrong");

  chk_swi_reserved: assert property (
    s_ff.phase == PH_READ && s_ff.addr == `SOFTWARE_INTERRUPT_CONTROL_ADDR
      |=> ahb_o.hrdata[31:3] == 29'h0 && !ahb_o.hrdata[0])
    else $error("reserved software interrupt bits read nonzero");

  chk_plain_mode: assert property (
    !irq_vec_mode |-> s_ff.in_service == 8'h00)
    else $error("levels held in service without vectored mode");

  chk_reset_quiet: assert property (
    !$past(hresetn) |-> !irq_req && !fiq_req && s_ff.irq_en == 32'h0 &&
      s_ff.fiq_en == 32'h0 && s_ff.swi == 2'h0)
    else $error("state not cleared after reset");

  cov_vector_read: cover property (
    irq_vec_mode && s_ff.phase == PH_READ &&
    s_ff.addr == `VECTOR_READBACK_ADDR && best_lvl != 4'h0);
  cov_fast_rise: cover property ($rose(fiq_req));
  cov_nested_two: cover property (s_ff.in_service[7] && s_ff.in_service[0]);
  cov_both_lines: cover property (irq_req && fiq_req);
  cov_service_flush: cover property (
    s_ff.phase == PH_WRITE && s_ff.addr == `NESTING_CONTROL_ADDR &&
    s_ff.in_service != 8'h00);

endmodule // irq_fiq_interrupt_controller

//--- periph_model.sv
/*
  Peripheral side of the interrupt controller: one request level a source.
  Assumes the bench changes the wanted levels just after a rising edge.
*/
module periph_model #(
  parameter int SRC_COUNT = 28
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Levels asked for by the bench.
  input wire logic [SRC_COUNT-1:2] want,
  // Request lines to the controller.
  output logic [SRC_COUNT-1:2] req_ff
);
  timeunit 1ns;
  timeprecision 1ps;

  // Each line follows the level asked for by the bench, one clock later.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_ff <= '0;
    end else begin
      req_ff <= want;
    end
  end
endmodule // periph_model

//--- irq_fiq_interrupt_controller_bench.sv
/*
  Self-checking bench of the interrupt controller over AHB-Lite.
  Assumes the constants header, the package and the peripheral model.
*/
`include "irq_fiq_consts.svh"

module irq_fiq_interrupt_controller_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import irq_fiq_pkg::*;

  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  ahb_in_type bus_in = '0;
  ahb_in_type ahb_in;
  ahb_out_type ahb_out;
  logic [27:2] want = '0;
  logic [27:2] periph_req;
  logic irq_req;
  logic fiq_req;
  logic [31:0] rdata;
  int fail_count = 0;
  int total_checks = 0;

  always #25 hclk = ~hclk;

  always_comb begin
    ahb_in = bus_in;
    ahb_in.hready = ahb_out.hreadyout;
  end

  periph_model periph_model_inst (
    .hclk(hclk),
    .hresetn(hresetn),
    .want(want),
    .req_ff(periph_req)
  );

  irq_fiq_interrupt_controller irq_fiq_interrupt_controller_inst (
    .hclk(hclk),
    .hresetn(hresetn),
    .ahb_i(ahb_in),
    .ahb_o(ahb_out),
    .periph_irq_req(periph_req),
    .irq_req(irq_req),
    .fiq_req(fiq_req)
  );

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (ahb_out.hreadyout !== 1'b1 && n < 20);
    if (ahb_out.hreadyout !== 1'b1) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      close_out();
    end
  endtask

  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d);
    bus_in.hsel <= 1'b1;
    bus_in.haddr <= a;
    bus_in.htrans <= 2'h2;
    bus_in.hwrite <= w;
    bus_in.hsize <= 3'h2;
    wait_ready();
    bus_in.hsel <= 1'b0;
    bus_in.htrans <= 2'h0;
    bus_in.hwdata <= d;
    wait_ready();
    rdata = ahb_out.hrdata;
    check({31'h0, ahb_out.hresp}, 32'h0);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check(rdata, e);
  endtask

  task automatic lines(input logic i, input logic f);
    repeat (6) @(posedge hclk);
    check({31'h0, irq_req}, {31'h0, i});
    check({31'h0, fiq_req}, {31'h0, f});
  endtask

  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`IRQ_ENABLE_SET_ADDR, 32'h0);
    rd(`FAST_ENABLE_SET_ADDR, 32'h0);
    rd(`SOFTWARE_INTERRUPT_CONTROL_ADDR, 32'h0);
    rd(`VECTOR_BASE_ADDR, 32'h0);
    lines(1'b0, 1'b0);
    want[5] <= 1'b1;
    lines(1'b0, 1'b0);
    rd(`IRQ_RAW_SIGNAL_ADDR, 32'h20);
    rd(`FAST_RAW_SIGNAL_ADDR, 32'h20);
    rd(`IRQ_MASKED_STATUS_ADDR, 32'h0);
    wr(`IRQ_ENABLE_SET_ADDR, 32'h20);
    wr(`IRQ_ENABLE_SET_ADDR, 32'h0);
    wr(`IRQ_MASKED_STATUS_ADDR, 32'h0);
    rd(`IRQ_ENABLE_SET_ADDR, 32'h20);
    rd(`IRQ_MASKED_STATUS_ADDR, 32'h20);
    lines(1'b1, 1'b0);
    wr(`FAST_ENABLE_SET_ADDR, 32'h20);
    wr(`FAST_ENABLE_SET_ADDR, 32'h0);
    rd(`IRQ_ENABLE_SET_ADDR, 32'h0);
    rd(`FAST_ENABLE_SET_ADDR, 32'h20);
    rd(`FAST_MASKED_STATUS_ADDR, 32'h21);
    rd(`IRQ_RAW_SIGNAL_ADDR, 32'h21);
    rd(`FAST_RAW_SIGNAL_ADDR, 32'h21);
    lines(1'b0, 1'b1);
    wr(`IRQ_ENABLE_SET_ADDR, 32'h30);
    rd(`FAST_ENABLE_SET_ADDR, 32'h0);
    lines(1'b1, 1'b0);
    wr(`IRQ_ENABLE_CLEAR_ADDR, 32'h10);
    rd(`IRQ_ENABLE_SET_ADDR, 32'h20);
    rd(`IRQ_ENABLE_CLEAR_ADDR, 32'h0);
    wr(`FAST_ENABLE_SET_ADDR, 32'hc0);
    wr(`FAST_ENABLE_CLEAR_ADDR, 32'h80);
    rd(`FAST_ENABLE_SET_ADDR, 32'h40);
    wr(`IRQ_ENABLE_CLEAR_ADDR, 32'h20);
    wr(`FAST_ENABLE_CLEAR_ADDR, 32'h40);
    lines(1'b0, 1'b0);
    wr(`SOFTWARE_INTERRUPT_CONTROL_ADDR, 32'h2);
    rd(`IRQ_RAW_SIGNAL_ADDR, 32'h22);
    rd(`IRQ_MASKED_STATUS_ADDR, 32'h2);
    lines(1'b1, 1'b0);
    wr(`SOFTWARE_INTERRUPT_CONTROL_ADDR, 32'hffffffff);
    rd(`SOFTWARE_INTERRUPT_CONTROL_ADDR, 32'h6);
    rd(`FAST_MASKED_STATUS_ADDR, 32'h3);
    lines(1'b1, 1'b1);
    wr(`SOFTWARE_INTERRUPT_CONTROL_ADDR, 32'h0);
    rd(`IRQ_MASKED_STATUS_ADDR, 32'h0);
    lines(1'b0, 1'b0);
    wr(`VECTOR_BASE_ADDR, 32'hffffffff);
    rd(`VECTOR_BASE_ADDR, 32'hffff);
    wr(`NESTING_CONTROL_ADDR, 32'h3);
    rd(`NESTING_CONTROL_ADDR, 32'h3);
    want[3] <= 1'b1;
    wr(`IRQ_ENABLE_SET_ADDR, 32'h28);
    lines(1'b1, 1'b0);
    rd(`VECTOR_READBACK_ADDR, 32'h007fff8c);
    lines(1'b0, 1'b0);
    wr(`SERVICE_DONE_ADDR, 32'h0);
    lines(1'b1, 1'b0);
    wr(`PRIORITY_BASE_ADDR, 32'h00300000);
    rd(`PRIORITY_BASE_ADDR, 32'h00300000);
    rd(`VECTOR_READBACK_ADDR, 32'h007fff94);
    lines(1'b0, 1'b0);
    wr(32'hffff0200, 32'hffffffff);
    rd(32'hffff0200, 32'h0);
    wr(`NESTING_CONTROL_ADDR, 32'h2);
    rd(`NESTING_CONTROL_ADDR, 32'h2);
    lines(1'b1, 1'b0);
    wr(`NESTING_CONTROL_ADDR, 32'h3);
    lines(1'b1, 1'b0);
    wr(`SOFTWARE_INTERRUPT_CONTROL_ADDR, 32'h6);
    lines(1'b1, 1'b1);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`IRQ_ENABLE_SET_ADDR, 32'h0);
    rd(`NESTING_CONTROL_ADDR, 32'h0);
    rd(`SOFTWARE_INTERRUPT_CONTROL_ADDR, 32'h0);
    rd(`VECTOR_BASE_ADDR, 32'h0);
    lines(1'b0, 1'b0);
    close_out();
  end
endmodule // irq_fiq_interrupt_controller_bench
